// ===== sfil_pkg.sv
// sfil_pkg: constants for the serial flash image loader
// assumes a single 25 MHz system clock domain
package sfil_pkg;
	localparam logic [31:0] SFIL_CODE_BASE    = 32'hfff8_0000;
	localparam logic [31:0] SFIL_CODE_LAST    = 32'hfff8_1aff;
	localparam logic [31:0] SFIL_VEC_BASE     = 32'hfff8_1b00;
	localparam logic [31:0] SFIL_VEC_LAST     = 32'hfff8_1b4f;
	localparam logic [31:0] SFIL_STACK_BASE   = 32'hfff8_1c00;
	localparam logic [31:0] SFIL_STACK_LAST   = 32'hfff8_1fff;
	localparam logic [31:0] SFIL_SP_INIT      = 32'hfff8_2000;
	localparam logic [31:0] SFIL_FPSC_VALUE   = 32'h0004_0001;
	localparam logic [3:0]  SFIL_IMASK_ALL    = 4'hf;
	localparam int          SFIL_IMASK_POS    = 4;
	localparam int          SFIL_VEC_LAST_NUM = 18;
	localparam logic [23:0] SFIL_DESC_ADDR    = 24'h00_2000;
	localparam logic [23:0] SFIL_DESC_END_ADR = 24'h00_2004;
	localparam logic [23:0] SFIL_IMAGE_ADDR   = 24'h00_2000;
	localparam logic [2:0]  SFIL_DESC_BYTES   = 3'h7;
	localparam logic [31:0] SFIL_ENTRY_OFS    = 32'h0000_0008;
	localparam logic [31:0] SFIL_SP_OFS       = 32'h0000_000c;
	localparam logic [7:0]  SFIL_FAST_READ    = 8'h0b;
	localparam int          SFIL_LOADER_SIZE  = 8192;
	localparam logic [3:0]  SFIL_CLK_DIV      = 4'h1;
endpackage

// ===== sfil_spi_byte.sv
// sfil_spi_byte: one spi mode-0 byte exchange, msb first
// assumes select is held by the caller between bytes
`timescale 1ns/1ps
`default_nettype none
module sfil_spi_byte
	import sfil_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic [7:0] tx_byte,
	input  wire logic       miso,
	output logic            sck,
	output logic            mosi,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rx_byte
);
	logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
	logic [3:0] bit_r, bit_nxt, div_r, div_nxt;
	logic       sck_r, sck_nxt, busy_r, busy_nxt, done_r, done_nxt;

	always_comb
	begin
		sh_nxt   = sh_r;
		rx_nxt   = rx_r;
		bit_nxt  = bit_r;
		div_nxt  = div_r;
		sck_nxt  = sck_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (!busy_r)
		begin
			if (start)
			begin
				sh_nxt   = tx_byte;
				bit_nxt  = 4'h0;
				div_nxt  = 4'h0;
				busy_nxt = 1'b1;
			end
		end
		else if (div_r != SFIL_CLK_DIV)
			div_nxt = div_r + 4'h1;
		else
		begin
			div_nxt = 4'h0;
			if (!sck_r)
			begin
				sck_nxt = 1'b1;
				rx_nxt  = {rx_r[6:0], miso};
			end
			else
			begin
				sck_nxt = 1'b0;
				sh_nxt  = {sh_r[6:0], 1'b0};
				bit_nxt = bit_r + 4'h1;
				if (bit_r == 4'h7)
				begin
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			sh_r   <= 8'h00;
			rx_r   <= 8'h00;
			bit_r  <= 4'h0;
			div_r  <= 4'h0;
			sck_r  <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			sh_r   <= sh_nxt;
			rx_r   <= rx_nxt;
			bit_r  <= bit_nxt;
			div_r  <= div_nxt;
			sck_r  <= sck_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end

	assign sck     = sck_r;
	assign mosi    = sh_r[7];
	assign busy    = busy_r;
	assign done    = done_r;
	assign rx_byte = rx_r;
endmodule // sfil_spi_byte
`default_nettype wire

// ===== sfil_loader.sv
// sfil_loader: boot loader sequencer, flash image to internal ram
// assumes a spi flash answering fast read and a ram write port with no stall
`timescale 1ns/1ps
`default_nettype none
// Contract
// - loader code occupies its fixed ram range
// - temporary vector table follows code region
// - loader stack sits below initial pointer
// - stack pointer set first; entry at base
// - float control set single precision, round-zero
// - vector base points at table, vectors 0-18
// - interrupt mask field set to all ones
// - read eight descriptor bytes at fixed address
// - first word start, second word end
// - copy image contiguously from flash to ram
// - write back cache after the copy
// - stack pointer from image bytes 12-15
// - finally jump to entry at bytes 8-11
// - fetch image with fast read opcode
// - loader image has fixed 8 KB size
module sfil_loader
	import sfil_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        flash_miso,
	output logic             flash_sck,
	output logic             flash_mosi,
	output logic             flash_sel_n,
	output logic             ram_we,
	output logic [31:0]      ram_addr,
	output logic [7:0]       ram_wdata,
	output logic             cache_wb_req,
	input  wire logic        cache_wb_done,
	output logic [31:0]      stack_pointer_register,
	output logic [31:0]      float_status_control,
	output logic [31:0]      vector_base_pointer,
	output logic [31:0]      processor_status_word,
	output logic [31:0]      jump_addr,
	output logic             jump,
	output logic             loader_busy,
	output logic             desc_error,
	output logic [31:0]      loader_region_last
);
	typedef enum {
		ST_SETUP, ST_CMD, ST_ADDR, ST_DUMMY, ST_DESC, ST_GAP,
		ST_DATA, ST_WB, ST_JUMP, ST_DONE
	} sfil_state_e;

	sfil_state_e state_r, state_nxt;
	logic [31:0] sp_r, sp_nxt, fpsc_r, fpsc_nxt, vbr_r, vbr_nxt, psw_r, psw_nxt;
	logic [31:0] start_r, start_nxt, end_r, end_nxt, ptr_r, ptr_nxt;
	logic [31:0] entry_r, entry_nxt, jaddr_r, jaddr_nxt;
	logic [23:0] faddr_r, faddr_nxt;
	logic [1:0]  acnt_r, acnt_nxt;
	logic [2:0]  dcnt_r, dcnt_nxt;
	logic        second_r, second_nxt, sel_n_r, sel_n_nxt;
	logic        we_r, we_nxt, wb_r, wb_nxt, jump_r, jump_nxt, err_r, err_nxt;
	logic [31:0] waddr_r, waddr_nxt;
	logic [7:0]  wdata_r, wdata_nxt;
	logic        sb_start, sb_busy, sb_done;
	logic [7:0]  sb_tx, sb_rx;

	// byte of a 3-byte flash address, msb first
	function automatic logic [7:0] addr_byte(input logic [23:0] a, input logic [1:0] i);
		unique case (i)
			2'h0: addr_byte = a[23:16];
			2'h1: addr_byte = a[15:8];
			default: addr_byte = a[7:0];
		endcase
	endfunction

	// shift a received byte into a big-endian word
	function automatic logic [31:0] push_be(input logic [31:0] w, input logic [7:0] b);
		push_be = {w[23:0], b};
	endfunction

	sfil_spi_byte u_byte (
		.sys_clk (sys_clk),
		.rst     (rst),
		.start   (sb_start),
		.tx_byte (sb_tx),
		.miso    (flash_miso),
		.sck     (flash_sck),
		.mosi    (flash_mosi),
		.busy    (sb_busy),
		.done    (sb_done),
		.rx_byte (sb_rx)
	);

	always_comb
	begin
		state_nxt  = state_r;
		sp_nxt     = sp_r;
		fpsc_nxt   = fpsc_r;
		vbr_nxt    = vbr_r;
		psw_nxt    = psw_r;
		start_nxt  = start_r;
		end_nxt    = end_r;
		ptr_nxt    = ptr_r;
		entry_nxt  = entry_r;
		jaddr_nxt  = jaddr_r;
		faddr_nxt  = faddr_r;
		acnt_nxt   = acnt_r;
		dcnt_nxt   = dcnt_r;
		second_nxt = second_r;
		sel_n_nxt  = sel_n_r;
		we_nxt     = 1'b0;
		waddr_nxt  = waddr_r;
		wdata_nxt  = wdata_r;
		wb_nxt     = wb_r;
		jump_nxt   = 1'b0;
		err_nxt    = err_r;
		sb_start   = 1'b0;
		sb_tx      = 8'h00;
		unique case (state_r)
			ST_SETUP:
			begin
				// stack, float, vectors and mask all set in one cycle
				sp_nxt    = SFIL_SP_INIT;
				fpsc_nxt  = SFIL_FPSC_VALUE;
				vbr_nxt   = SFIL_VEC_BASE;
				psw_nxt   = psw_r | ({28'h0, SFIL_IMASK_ALL} << SFIL_IMASK_POS);
				faddr_nxt = SFIL_DESC_ADDR;
				second_nxt = 1'b0;
				state_nxt = ST_CMD;
			end
			ST_CMD:
				if (!sb_busy)
				begin
					sel_n_nxt = 1'b0;
					sb_start  = 1'b1;
					sb_tx     = SFIL_FAST_READ;
					acnt_nxt  = 2'h0;
					state_nxt = ST_ADDR;
				end
			ST_ADDR:
				if (sb_done)
				begin
					sb_start = 1'b1;
					sb_tx    = addr_byte(faddr_r, acnt_r);
					acnt_nxt = acnt_r + 2'h1;
					if (acnt_r == 2'h2)
						state_nxt = ST_DUMMY;
				end
			ST_DUMMY:
				if (sb_done)
				begin
					sb_start  = 1'b1;
					state_nxt = ST_GAP;
				end
			ST_DESC:
				if (sb_done)
				begin
					if (dcnt_r[2])
						end_nxt = push_be(end_r, sb_rx);
					else
						start_nxt = push_be(start_r, sb_rx);
					dcnt_nxt = dcnt_r + 3'h1;
					if (dcnt_r == SFIL_DESC_BYTES)
					begin
						// image starts with the descriptor: reread from its base
						sel_n_nxt  = 1'b1;
						second_nxt = 1'b1;
						faddr_nxt  = SFIL_IMAGE_ADDR;
						state_nxt  = ST_CMD;
					end
					else
						sb_start = 1'b1;
				end
			ST_GAP:
				// done of the dummy byte carries no data
				if (sb_done)
				begin
					sb_start  = 1'b1;
					dcnt_nxt  = 3'h0;
					state_nxt = second_r ? ST_DATA : ST_DESC;
					if (second_r)
					begin
						ptr_nxt = start_r;
						err_nxt = (end_r < start_r);
					end
				end
			ST_DATA:
				if (sb_done)
				begin
					we_nxt    = 1'b1;
					waddr_nxt = ptr_r;
					wdata_nxt = sb_rx;
					if (ptr_r - start_r >= SFIL_ENTRY_OFS &&
						ptr_r - start_r < SFIL_SP_OFS)
						entry_nxt = push_be(entry_r, sb_rx);
					else if (ptr_r - start_r >= SFIL_SP_OFS &&
						ptr_r - start_r < SFIL_SP_OFS + 32'h4)
						jaddr_nxt = push_be(jaddr_r, sb_rx);
					ptr_nxt = ptr_r + 32'h1;
					if (ptr_r >= end_r || err_r)
					begin
						sel_n_nxt = 1'b1;
						state_nxt = ST_WB;
					end
					else
						sb_start = 1'b1;
				end
			ST_WB:
				// request only once the last byte has been written
				if (!wb_r)
					wb_nxt = 1'b1;
				else if (cache_wb_done)
				begin
					wb_nxt    = 1'b0;
					sp_nxt    = jaddr_r;
					state_nxt = ST_JUMP;
				end
			ST_JUMP:
			begin
				jaddr_nxt = entry_r;
				jump_nxt  = 1'b1;
				state_nxt = ST_DONE;
			end
			ST_DONE:
				state_nxt = ST_DONE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			state_r  <= ST_SETUP;
			sp_r     <= 32'h0;
			fpsc_r   <= 32'h0;
			vbr_r    <= 32'h0;
			psw_r    <= 32'h0;
			start_r  <= 32'h0;
			end_r    <= 32'h0;
			ptr_r    <= 32'h0;
			entry_r  <= 32'h0;
			jaddr_r  <= 32'h0;
			faddr_r  <= 24'h0;
			acnt_r   <= 2'h0;
			dcnt_r   <= 3'h0;
			second_r <= 1'b0;
			sel_n_r  <= 1'b1;
			we_r     <= 1'b0;
			waddr_r  <= 32'h0;
			wdata_r  <= 8'h00;
			wb_r     <= 1'b0;
			jump_r   <= 1'b0;
			err_r    <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			sp_r     <= sp_nxt;
			fpsc_r   <= fpsc_nxt;
			vbr_r    <= vbr_nxt;
			psw_r    <= psw_nxt;
			start_r  <= start_nxt;
			end_r    <= end_nxt;
			ptr_r    <= ptr_nxt;
			entry_r  <= entry_nxt;
			jaddr_r  <= jaddr_nxt;
			faddr_r  <= faddr_nxt;
			acnt_r   <= acnt_nxt;
			dcnt_r   <= dcnt_nxt;
			second_r <= second_nxt;
			sel_n_r  <= sel_n_nxt;
			we_r     <= we_nxt;
			waddr_r  <= waddr_nxt;
			wdata_r  <= wdata_nxt;
			wb_r     <= wb_nxt;
			jump_r   <= jump_nxt;
			err_r    <= err_nxt;
		end

	assign flash_sel_n            = sel_n_r;
	assign ram_we                 = we_r;
	assign ram_addr               = waddr_r;
	assign ram_wdata              = wdata_r;
	assign cache_wb_req           = wb_r;
	assign stack_pointer_register = sp_r;
	assign float_status_control   = fpsc_r;
	assign vector_base_pointer    = vbr_r;
	assign processor_status_word  = psw_r;
	assign jump_addr              = jaddr_r;
	assign jump                   = jump_r;
	assign loader_busy            = (state_r != ST_DONE);
	assign desc_error             = err_r;
	// reserved loader footprint: code, vectors, stack
	assign loader_region_last     = SFIL_STACK_LAST;
endmodule // sfil_loader
`default_nettype wire

// ===== sfil_loader_asserts.sv
// sfil_loader_asserts: port checks for sfil_loader
// assumes one sys_clk domain, rst async high
`timescale 1ns/1ps
`default_nettype none
module sfil_loader_asserts
	import sfil_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        flash_sck,
	input wire logic        flash_sel_n,
	input wire logic        ram_we,
	input wire logic [31:0] ram_addr,
	input wire logic        cache_wb_req,
	input wire logic        cache_wb_done,
	input wire logic [31:0] float_status_control,
	input wire logic [31:0] vector_base_pointer,
	input wire logic [31:0] processor_status_word,
	input wire logic        jump,
	input wire logic        desc_error
);
	logic [31:0] last_r;
	logic        seen_r;
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			last_r <= 32'h0;
			seen_r <= 1'b0;
		end
		else if (ram_we)
		begin
			last_r <= ram_addr;
			seen_r <= 1'b1;
		end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_fpsc; !$past(rst) |-> float_status_control == SFIL_FPSC_VALUE; endproperty
	property p_vbp; !$past(rst) |-> vector_base_pointer == SFIL_VEC_BASE; endproperty
	property p_imask; !$past(rst) |-> processor_status_word[7:4] == SFIL_IMASK_ALL; endproperty
	property p_sck_idle; flash_sel_n |-> !flash_sck; endproperty
	property p_addr_inc; ram_we && seen_r && !desc_error |-> ram_addr == last_r + 32'h1; endproperty
	property p_wb_hold; cache_wb_req && !cache_wb_done |=> cache_wb_req; endproperty
	property p_wb_jump; cache_wb_req && cache_wb_done |-> ##[1:3] jump; endproperty
	property p_jump_once; jump |=> !jump [*4]; endproperty
	property p_no_we_wb; cache_wb_req |-> !ram_we && flash_sel_n; endproperty
	a_fpsc: assert property (p_fpsc) else $error("float control wrong");
	a_vbp: assert property (p_vbp) else $error("vector base wrong");
	a_imask: assert property (p_imask) else $error("mask field wrong");
	a_sck_idle: assert property (p_sck_idle) else $error("sck moves unselected");
	a_addr_inc: assert property (p_addr_inc) else $error("ram address skip");
	a_wb_hold: assert property (p_wb_hold) else $error("writeback dropped");
	a_wb_jump: assert property (p_wb_jump) else $error("no jump after wb");
	a_jump_once: assert property (p_jump_once) else $error("jump repeats");
	a_no_we_wb: assert property (p_no_we_wb) else $error("copy during wb");
	c_jump: cover property (jump);
	c_err: cover property (desc_error);
	c_wb: cover property (cache_wb_req && cache_wb_done);
endmodule // sfil_loader_asserts
bind sfil_loader sfil_loader_asserts u_chk (.sys_clk, .rst, .flash_sck, .flash_sel_n,
	.ram_we, .ram_addr, .cache_wb_req, .cache_wb_done, .float_status_control,
	.vector_base_pointer, .processor_status_word, .jump, .desc_error);
`default_nettype wire

// ===== sfil_flash_model.sv
// sfil_flash_model: spi mode-0 flash answering fast reads of the image
// assumes header of opcode, 3 address bytes, dummy
`timescale 1ns/1ps
`default_nettype none
module sfil_flash_model
#(
	parameter logic [31:0] START  = 32'h1c00_0000,
	parameter logic [31:0] LAST   = 32'h1c00_0017,
	parameter logic [31:0] ENTRY  = 32'h1c00_0100,
	parameter logic [31:0] APP_SP = 32'h1c00_8000
)
(
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        sel_n,
	input  wire logic        rev,
	output var logic         miso,
	output var logic [39:0]  hdr
);
	int          cnt = 0;
	logic [31:0] w;
	initial miso = 1'b0;
	initial hdr = 40'h0;
	// descriptor, entry word, stack word, then filler words
	function automatic logic [31:0] word(input int i);
		if (i < 4) return START;
		if (i < 8) return rev ? START - 32'h1 : LAST;
		return (i % 8 < 4) ? ENTRY : APP_SP;
	endfunction
	// released line shows the inverse of its last bit
	always @(posedge sel_n or posedge sck or negedge sck)
		if (sel_n === 1'b1)
		begin
			if (cnt != 0)
			begin
				cnt  = 0;
				miso = ~miso;
			end
		end
		else if (sck === 1'b1)
		begin
			if (cnt < 40)
				hdr = {hdr[38:0], mosi};
			cnt = cnt + 1;
		end
		else if (sel_n === 1'b0 && cnt >= 40)
		begin
			w = word((cnt - 40) / 8);
			miso = w[31 - 8 * (((cnt - 40) / 8) % 4) - (cnt - 40) % 8];
		end
endmodule // sfil_flash_model
`default_nettype wire

// ===== tb_top.sv
// tb_top: boot runs of sfil_loader against the flash model
// assumes 25 MHz sys_clk and a cache that acks after a delay
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import sfil_pkg::*;
;
	localparam logic [31:0] START  = 32'h1c00_0000;
	localparam logic [31:0] LAST   = 32'h1c00_0017;
	localparam logic [31:0] ENTRY  = 32'h1c00_0100;
	localparam logic [31:0] APP_SP = 32'h1c00_8000;
	logic        sys_clk, rst, miso, sck, mosi, sel_n, ram_we, rev;
	logic        wb_req, wb_done, jump, busy, derr;
	logic [31:0] ram_addr, sp, fsc, vbp, psw, jaddr, region, exp_addr;
	logic [7:0]  wdata;
	logic [39:0] hdr;
	int          n_fail, comparisons, n_we, wb_cnt;
	sfil_loader dut (.sys_clk, .rst, .flash_miso(miso), .flash_sck(sck),
		.flash_mosi(mosi), .flash_sel_n(sel_n), .ram_we, .ram_addr, .ram_wdata(wdata),
		.cache_wb_req(wb_req), .cache_wb_done(wb_done), .stack_pointer_register(sp),
		.float_status_control(fsc), .vector_base_pointer(vbp),
		.processor_status_word(psw), .jump_addr(jaddr), .jump, .loader_busy(busy),
		.desc_error(derr), .loader_region_last(region));
	sfil_flash_model #(.START(START), .LAST(LAST), .ENTRY(ENTRY), .APP_SP(APP_SP))
		flash (.sck, .mosi, .sel_n, .rev, .miso, .hdr);
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// image byte k as the flash holds it from the descriptor on
	function automatic logic [7:0] img_byte(input logic [31:0] k);
		logic [31:0] wd;
		wd = (k < 4) ? START : (k < 8) ? LAST : (k % 8 < 4) ? ENTRY : APP_SP;
		return wd[8 * (3 - k % 4) +: 8];
	endfunction
	always @(negedge sys_clk)
		if (rst === 1'b1)
		begin
			exp_addr = START;
			n_we = 0;
		end
		else if (ram_we === 1'b1 && derr !== 1'b1)
		begin
			chk("ram_addr", exp_addr, ram_addr);
			chk("ram_wdata", {24'h0, img_byte(exp_addr - START)}, {24'h0, wdata});
			exp_addr = exp_addr + 32'h1;
			n_we++;
		end
	// late cache acknowledge, one cycle
	always @(posedge sys_clk)
	begin
		wb_cnt <= (wb_req === 1'b1) ? wb_cnt + 1 : 0;
		wb_done <= (wb_cnt == 5);
	end
	task automatic boot(input logic r);
		@(posedge sys_clk);
		rev <= r;
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
	endtask
	task automatic wait_ev(input logic want_err);
		for (int i = 0; i <= 5000; i++)
		begin
			@(negedge sys_clk);
			if ((want_err ? derr : jump) === 1'b1) return;
		end
		n_fail++;
		$display("[ERR] wait expected %h seen %h", 1'b1, 1'b0);
		final_report();
	endtask
	initial
	begin
		rst = 1'b1;
		rev = 1'b0;
		n_fail = 0;
		comparisons = 0;
		boot(1'b0);
		repeat (4) @(negedge sys_clk);
		chk("sp_init", SFIL_SP_INIT, sp);
		chk("fpsc", SFIL_FPSC_VALUE, fsc);
		chk("vbp", SFIL_VEC_BASE, vbp);
		chk("imask", {28'h0, SFIL_IMASK_ALL}, {28'h0, psw[7:4]});
		chk("region", SFIL_STACK_LAST, region);
		chk("loader_size", SFIL_CODE_BASE + 32'(SFIL_LOADER_SIZE) - 32'h1, region);
		chk("busy", 32'h1, {31'h0, busy});
		wait_ev(1'b0);
		chk("entry", ENTRY, jaddr);
		chk("busy_end", 32'h0, {31'h0, busy});
		chk("desc_ok", 32'h0, {31'h0, derr});
		chk("opcode", {24'h0, SFIL_FAST_READ}, {24'h0, hdr[39:32]});
		chk("faddr", {8'h0, SFIL_DESC_ADDR}, {8'h0, hdr[31:8]});
		chk("n_we", LAST - START + 32'h1, 32'(n_we));
		@(negedge sys_clk);
		chk("app_sp", APP_SP, sp);
		boot(1'b1);
		wait_ev(1'b1);
		chk("desc_error", 32'h1, {31'h0, derr});
		final_report();
	end
endmodule // tb_top
`default_nettype wire
